//--- src/ive_pkg.sv
// package for the interrupt vector and enable block: map, offsets, fields, types
package ive_pkg;

    // ------------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_ENABLE = 4'h0;
    localparam logic [3:0] OFF_STATUS = 4'h1;
    localparam logic [3:0] OFF_MASK = 4'h2;
    localparam logic [3:0] OFF_PENDING = 4'h3;
    localparam logic [3:0] OFF_FLAGS = 4'h4;
    localparam logic [3:0] OFF_VECTOR = 4'h5;
    localparam logic [3:0] OFF_CONFIG = 4'h6;

    // ------------------------------------------------------------------
    // enable register layout
    // ------------------------------------------------------------------
    localparam int EN_W = 16;
    localparam logic [15:0] EN_IMPL_MASK = 16'h00F7;
    localparam logic [15:0] EN_RESET = 16'h0000;
    localparam int BIT_FAULT_B = 0;
    localparam int BIT_UART1_ERR = 1;
    localparam int BIT_UART2_ERR = 2;
    localparam int BIT_DMA6 = 4;
    localparam int BIT_DMA7 = 5;
    localparam int BIT_CAN1_TX = 6;
    localparam int BIT_CAN2_TX = 7;

    // ------------------------------------------------------------------
    // vector map
    // ------------------------------------------------------------------
    localparam int NSRC = 27;
    localparam logic [7:0] IRQ_OFFSET = 8'h08;
    localparam logic [23:0] PRIMARY_BASE = 24'h000004;
    localparam logic [23:0] ALT_DELTA = 24'h000100;
    localparam logic [6:0] FIRST_VEC = 7'h36;
    localparam logic [6:0] LAST_VEC = 7'h7D;
    localparam logic [6:0] NO_VEC = 7'h00;

    // source index -> vector number (index 0..26, traps 1..5 at the top)
    localparam logic [6:0] SRC_VEC [NSRC] = '{
        7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h3C, 7'h3D, 7'h3E, 7'h3F,
        7'h40, 7'h41, 7'h42, 7'h45, 7'h47, 7'h48, 7'h49, 7'h4A, 7'h4C, 7'h4D,
        7'h4E, 7'h4F, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05
    };
    // source index of dma4, fault a, the sources gated by the enable register and the first trap
    localparam int SRC_DMA4 = 0;
    localparam int SRC_FAULT_A = 14;
    localparam int SRC_FAULT_B = 15;
    localparam int SRC_UART1_ERR = 16;
    localparam int SRC_UART2_ERR = 17;
    localparam int SRC_DMA6 = 18;
    localparam int SRC_DMA7 = 19;
    localparam int SRC_CAN1_TX = 20;
    localparam int SRC_CAN2_TX = 21;
    localparam int SRC_TRAP_FIRST = 22;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } ive_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [6:0] vector;
        logic [7:0] irq;
        logic [23:0] addr;
    } ive_vec_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_PRESENT = 3'b010,
        ST_ACK = 3'b100
    } ive_state_t;

endpackage

//--- src/ive_core.sv
// interrupt vector selection and enable register block
`timescale 1ns/1ns
`default_nettype none
module ive_core
    import ive_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // peripheral flags in, index order as the source table
    input wire logic [NSRC-1:0] src_flag,
    // cpu side
    output logic cpu_req,
    output ive_vec_t cpu_vec,
    input wire logic cpu_ack,
    // block interrupt
    output logic irq_out
);

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [23:0] vec_addr(input logic [6:0] v, input logic alt);
        logic [23:0] base;
        base = PRIMARY_BASE + {16'h0000, v, 1'b0};
        vec_addr = alt ? base + ALT_DELTA : base;
    endfunction

    ive_bus_req_t bus;
    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [15:0] enable_q;
    logic [1:0] status_q;
    logic [1:0] mask_q;
    logic alt_sel_q;
    logic [15:0] rdata_q;
    ive_state_t state_q;
    ive_vec_t vec_q;
    logic [4:0] sel_idx;
    logic sel_valid;

    wire wr_enable = bus.wr && hit(bus.addr, OFF_ENABLE);
    wire wr_status = bus.wr && hit(bus.addr, OFF_STATUS);
    wire wr_mask = bus.wr && hit(bus.addr, OFF_MASK);
    wire wr_config = bus.wr && hit(bus.addr, OFF_CONFIG);

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            enable_q <= EN_RESET;
        end else if (wr_enable) begin
            enable_q <= bus.wdata & EN_IMPL_MASK;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            mask_q <= 2'h0;
            alt_sel_q <= 1'b0;
        end else begin
            if (wr_mask) mask_q <= bus.wdata[1:0];
            if (wr_config) alt_sel_q <= bus.wdata[0];
        end
    end

    // ------------------------------------------------------------------
    // per source enable: gated sources use enable bits, others always on
    // ------------------------------------------------------------------
    logic [NSRC-1:0] src_en;
    logic [NSRC-1:0] pending;
    always_comb begin
        src_en = {NSRC{1'b1}};
        src_en[SRC_FAULT_B] = enable_q[BIT_FAULT_B];
        src_en[SRC_UART1_ERR] = enable_q[BIT_UART1_ERR];
        src_en[SRC_UART2_ERR] = enable_q[BIT_UART2_ERR];
        src_en[SRC_DMA6] = enable_q[BIT_DMA6];
        src_en[SRC_DMA7] = enable_q[BIT_DMA7];
        src_en[SRC_CAN1_TX] = enable_q[BIT_CAN1_TX];
        src_en[SRC_CAN2_TX] = enable_q[BIT_CAN2_TX];
    end
    // flags pass untouched; only the request is masked
    assign pending = src_flag & src_en;

    // ------------------------------------------------------------------
    // selection: traps first, then lowest vector wins
    // ------------------------------------------------------------------
    always_comb begin
        sel_idx = 5'h00;
        sel_valid = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (pending[i] && i < SRC_TRAP_FIRST) begin
                sel_idx = 5'(i);
                sel_valid = 1'b1;
            end
        end
        for (int i = NSRC - 1; i >= SRC_TRAP_FIRST; i--) begin
            if (pending[i]) begin
                sel_idx = 5'(i);
                sel_valid = 1'b1;
            end
        end
    end

    wire [6:0] sel_vec = SRC_VEC[sel_idx];
    wire sel_is_trap = sel_idx >= 5'(SRC_TRAP_FIRST);
    // traps carry no request number
    wire [7:0] sel_irq = sel_is_trap ? 8'h00 : {1'b0, sel_vec} - IRQ_OFFSET;

    // ------------------------------------------------------------------
    // cpu presentation: hold the vector until the cpu takes it
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            state_q <= ST_IDLE;
            vec_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (sel_valid) begin
                        state_q <= ST_PRESENT;
                        vec_q <= '{valid: 1'b1, vector: sel_vec, irq: sel_irq,
                                   addr: vec_addr(sel_vec, alt_sel_q)};
                    end
                end
                ST_PRESENT: begin
                    if (cpu_ack) begin
                        state_q <= ST_ACK;
                        vec_q <= '0;
                    end
                end
                // one idle cycle lets the source drop its flag
                ST_ACK: state_q <= ST_IDLE;
                default: begin
                    state_q <= ST_IDLE;
                    vec_q <= '0;
                end
            endcase
        end
    end

    assign cpu_req = (state_q == ST_PRESENT);
    assign cpu_vec = vec_q;

    // ------------------------------------------------------------------
    // block status: bit0 a request was blocked, bit1 a trap was seen
    // ------------------------------------------------------------------
    wire ev_blocked = |(src_flag & ~src_en);
    wire ev_trap = |src_flag[NSRC-1:SRC_TRAP_FIRST];
    wire [1:0] ev = {ev_trap, ev_blocked};
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            status_q <= 2'h0;
        end else begin
            // set beats clear in the same cycle
            status_q <= (status_q & ~(wr_status ? bus.wdata[1:0] : 2'h0)) | ev;
        end
    end
    assign irq_out = |(status_q & mask_q);

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [15:0] rd_mux;
    always_comb begin
        case (bus.addr)
            OFF_ENABLE: rd_mux = enable_q & EN_IMPL_MASK;
            OFF_STATUS: rd_mux = {14'h0000, status_q};
            OFF_MASK: rd_mux = {14'h0000, mask_q};
            OFF_PENDING: rd_mux = pending[15:0];
            OFF_FLAGS: rd_mux = {5'h00, src_flag[NSRC-1:16]};
            OFF_VECTOR: rd_mux = {cpu_req, vec_q.vector, vec_q.irq};
            OFF_CONFIG: rd_mux = {15'h0000, alt_sel_q};
            default: rd_mux = 16'h0000;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!rst_b) rdata_q <= 16'h0000;
        else if (bus.rd) rdata_q <= rd_mux;
        else rdata_q <= 16'h0000;
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // handshake steps seen from the cpu side
    // ------------------------------------------------------------------
    // idle with something pending: the vector is latched at this edge
    sequence s_capture;
        state_q == ST_IDLE && sel_valid;
    endsequence

    sequence s_offer;
        cpu_req && cpu_vec.valid;
    endsequence

    sequence s_taken;
        cpu_req && cpu_ack;
    endsequence

    // nothing offered and the stale vector wiped
    sequence s_released;
        !cpu_req && cpu_vec == '0;
    endsequence

    // ------------------------------------------------------------------
    // checks: enable register and read port
    // ------------------------------------------------------------------
    a_enable_reads_zero: assert property (@(posedge mclk) disable iff (!rst_b)
        $past(bus.rd) && $past(bus.addr) == OFF_ENABLE |-> reg_rdata[15:8] == 8'h00
            && reg_rdata[3] == 1'b0) else $error("enable reserved bits not zero");

    a_enable_write_lands: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_enable |=> enable_q == ($past(bus.wdata) & EN_IMPL_MASK))
        else $error("enable write lost");

    // first edge out of reset must see enable and mask at their reset values and no request
    a_enable_reset: assert property (@(posedge mclk) disable iff (!rst_b)
        !$past(rst_b) |-> enable_q == 16'h0000 && mask_q == 2'h0 && !cpu_req)
        else $error("register not cleared by reset");

    // stale read data would alias the next read, so they stand one cycle only
    a_read_one_cycle: assert property (@(posedge mclk) disable iff (!rst_b)
        !bus.rd |=> reg_rdata == 16'h0000) else $error("read data outlived its cycle");

    // guards the implemented-bit mask against a bad edit of the layout
    for (genvar b = 8; b < EN_W; b++) begin : g_rsvd_bit
        a_rsvd_bit_clear: assert property (@(posedge mclk) disable iff (!rst_b)
            !enable_q[b]) else $error("unimplemented enable bit set");
    end

    // ------------------------------------------------------------------
    // checks: gating and status
    // ------------------------------------------------------------------
    a_gate_blocks: assert property (@(posedge mclk) disable iff (!rst_b)
        !enable_q[BIT_DMA6] |-> !pending[SRC_DMA6]) else $error("dma6 not gated");

    a_gate_passes: assert property (@(posedge mclk) disable iff (!rst_b)
        enable_q[BIT_CAN2_TX] && src_flag[SRC_CAN2_TX] |-> pending[SRC_CAN2_TX])
        else $error("can2 tx not passed");

    a_pending_needs_both: assert property (@(posedge mclk) disable iff (!rst_b)
        pending[SRC_FAULT_B] |-> src_flag[SRC_FAULT_B] && enable_q[BIT_FAULT_B])
        else $error("fault b pending without cause");

    a_irq_follows: assert property (@(posedge mclk) disable iff (!rst_b)
        ev_blocked && mask_q[0] && !wr_mask |=> irq_out) else $error("irq missed");

    // set wins: a clear in the same cycle must not lose the event
    a_blocked_recorded: assert property (@(posedge mclk) disable iff (!rst_b)
        ev_blocked |=> status_q[0]) else $error("blocked request not recorded");

    a_trap_recorded: assert property (@(posedge mclk) disable iff (!rst_b)
        ev_trap |=> status_q[1]) else $error("trap not recorded");

    a_status_clears: assert property (@(posedge mclk) disable iff (!rst_b)
        wr_status && bus.wdata[0] && !ev_blocked |=> !status_q[0])
        else $error("status bit not cleared");

    // ------------------------------------------------------------------
    // checks: vector map and table addresses
    // ------------------------------------------------------------------
    a_irq_number: assert property (@(posedge mclk) disable iff (!rst_b)
        cpu_req && cpu_vec.vector >= FIRST_VEC |-> cpu_vec.irq == {1'b0, cpu_vec.vector} - 8'h08)
        else $error("request number mismatch");

    // table select is taken as it stands at capture, later changes do not apply
    a_primary_address: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 !alt_sel_q |=>
            cpu_vec.addr == 24'h000004 + {16'h0000, cpu_vec.vector, 1'b0})
        else $error("primary address wrong");

    a_alt_address: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 alt_sel_q |=>
            cpu_vec.addr == 24'h000004 + {16'h0000, cpu_vec.vector, 1'b0} + 24'h000100)
        else $error("alternate address wrong");

    a_dma4_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_IDLE && pending == (NSRC'(1) << SRC_DMA4) |=>
            cpu_vec.vector == 7'h36 && cpu_vec.irq == 8'h2E) else $error("dma4 vector wrong");

    a_dma7_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << SRC_DMA7) |=>
            cpu_vec.vector == 7'h4D && cpu_vec.irq == 8'h45) else $error("dma7 vector wrong");

    a_timer6_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << 1) |=>
            cpu_vec.vector == 7'h37 && cpu_vec.irq == 8'h2F) else $error("timer6 vector wrong");

    a_pwm_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << 11) |=>
            cpu_vec.vector == 7'h41 && cpu_vec.irq == 8'h39) else $error("pwm vector wrong");

    a_fault_b_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << SRC_FAULT_B) |=>
            cpu_vec.vector == 7'h48 && cpu_vec.irq == 8'h40) else $error("fault b vector wrong");

    a_can1_vector: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << SRC_CAN1_TX) |=>
            cpu_vec.vector == 7'h4E && cpu_vec.irq == 8'h46) else $error("can1 tx vector wrong");

    a_dma_err_trap: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 pending == (NSRC'(1) << (NSRC - 1)) |=>
            cpu_vec.vector == 7'h05 && cpu_vec.irq == 8'h00) else $error("dma trap wrong");

    a_trap_first: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture ##0 (|pending[NSRC-1:SRC_TRAP_FIRST]) |=>
            cpu_vec.vector < 7'h08 && cpu_vec.irq == 8'h00) else $error("trap lost priority");

    a_no_reserved_vec: assert property (@(posedge mclk) disable iff (!rst_b)
        cpu_req |-> cpu_vec.vector != 7'h46 && cpu_vec.vector != 7'h4B && cpu_vec.vector < 7'h50)
        else $error("reserved vector offered");

    a_no_reserved_trap: assert property (@(posedge mclk) disable iff (!rst_b)
        cpu_req && cpu_vec.vector < 7'h08 |-> cpu_vec.vector inside {[7'h01:7'h05]})
        else $error("reserved trap offered");

    // ------------------------------------------------------------------
    // checks: cpu handshake
    // ------------------------------------------------------------------
    a_capture_offers: assert property (@(posedge mclk) disable iff (!rst_b)
        s_capture |=> s_offer) else $error("pending request not offered");

    a_present_held: assert property (@(posedge mclk) disable iff (!rst_b)
        cpu_req && !cpu_ack |=> cpu_req && $stable(cpu_vec.vector))
        else $error("vector dropped before ack");

    // one rest cycle after ack so the source can drop its flag first
    a_ack_releases: assert property (@(posedge mclk) disable iff (!rst_b)
        s_taken |=> s_released ##1 !cpu_req) else $error("vector not released after ack");

    a_vec_clear_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        state_q == ST_IDLE |-> cpu_vec == '0) else $error("stale vector while idle");

endmodule
`default_nettype wire

//--- verification/ive_cpu_model.sv
// cpu core model: takes offered vectors and acks them after a set delay
`timescale 1ns/1ns
`default_nettype none
module ive_cpu_model
    import ive_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // vector link
    input wire logic cpu_req,
    input wire ive_vec_t cpu_vec,
    output logic cpu_ack,
    // ack delay and the last vector taken
    input wire logic [3:0] ack_delay,
    output ive_vec_t taken_vec,
    output logic taken
);
    logic [3:0] wait_q;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            cpu_ack <= 1'b0;
            wait_q <= 4'h0;
            taken <= 1'b0;
            taken_vec <= '0;
        end else begin
            taken <= cpu_ack & cpu_req;
            if (cpu_ack & cpu_req) begin
                taken_vec <= cpu_vec;
            end
            // ack is a one-cycle pulse, raised only while a vector is offered
            if (cpu_ack) begin
                cpu_ack <= 1'b0;
                wait_q <= 4'h0;
            end else if (cpu_req && wait_q >= ack_delay) begin
                cpu_ack <= 1'b1;
            end else if (cpu_req) begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/interrupt_vector_enable_test.sv
// self-checking bench for the interrupt vector and enable block
`timescale 1ns/1ns
`default_nettype none
module interrupt_vector_enable_test
    import ive_pkg::*;
;
    typedef struct {logic [6:0] vec; logic [3:0] gbit;} ive_row_t;
    // per source index: vector number, gating enable bit (F = ungated)
    ive_row_t rows [NSRC] = '{'{7'h36, 4'hF}, '{7'h37, 4'hF}, '{7'h38, 4'hF}, '{7'h39, 4'hF},
        '{7'h3A, 4'hF}, '{7'h3B, 4'hF}, '{7'h3C, 4'hF}, '{7'h3D, 4'hF}, '{7'h3E, 4'hF},
        '{7'h3F, 4'hF}, '{7'h40, 4'hF}, '{7'h41, 4'hF}, '{7'h42, 4'hF}, '{7'h45, 4'hF},
        '{7'h47, 4'hF}, '{7'h48, 4'h0}, '{7'h49, 4'h1}, '{7'h4A, 4'h2}, '{7'h4C, 4'h4},
        '{7'h4D, 4'h5}, '{7'h4E, 4'h6}, '{7'h4F, 4'h7}, '{7'h01, 4'hF}, '{7'h02, 4'hF},
        '{7'h03, 4'hF}, '{7'h04, 4'hF}, '{7'h05, 4'hF}};
    logic mclk, rst_b, reg_wr, reg_rd, cpu_ack, cpu_req, irq_out, taken, seen, g;
    logic [ADDR_W-1:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [NSRC-1:0] src_flag;
    logic [3:0] ack_delay;
    ive_vec_t cpu_vec, taken_vec;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    ive_core u_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flag(src_flag),
        .cpu_req(cpu_req), .cpu_vec(cpu_vec), .cpu_ack(cpu_ack), .irq_out(irq_out));
    ive_cpu_model u_cpu (.mclk(mclk), .rst_b(rst_b), .cpu_req(cpu_req), .cpu_vec(cpu_vec),
        .cpu_ack(cpu_ack), .ack_delay(ack_delay), .taken_vec(taken_vec), .taken(taken));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] sv, input logic [31:0] ev);
        samples_checked++;
        if (sv !== ev) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, ev, sv);
        end
    endtask
    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic reg_check(input string name, input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        chk(name, {16'h0000, reg_rdata}, {16'h0000, e});
    endtask
    task automatic set_flags(input logic [NSRC-1:0] f);
        @(posedge mclk);
        src_flag <= f;
    endtask
    task automatic quiet();
        seen = 1'b0;
        repeat (8) @(negedge mclk) seen = seen | cpu_req;
    endtask
    // waits for the cpu to take a vector, then checks all its fields
    task automatic take(input logic [6:0] v, input logic alt);
        int n;
        n = 0;
        do begin
            @(negedge mclk);
            n++;
        end while (taken !== 1'b1 && n < 50);
        chk("taken", {31'h0, taken}, 32'h1);
        chk("valid", {31'h0, taken_vec.valid}, 32'h1);
        chk("vector", {25'h0, taken_vec.vector}, {25'h0, v});
        chk("irq", {24'h0, taken_vec.irq}, (v < 7'h08) ? 32'h0 : {25'h0, v} - 32'h8);
        chk("addr", {8'h0, taken_vec.addr}, {25'h0, v} * 2 + 32'h4 + {23'h0, alt, 8'h0});
    endtask

    initial begin
        rst_b = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        src_flag = '0;
        ack_delay = 4'h0;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        chk("rst_out", {14'h0, cpu_req, irq_out, reg_rdata}, 32'h0);
        @(posedge mclk);
        rst_b <= 1'b1;
        reg_check("enable_rst", OFF_ENABLE, 16'h0000);
        for (int i = 0; i < NSRC; i++) begin
            g = (rows[i].gbit != 4'hF);
            reg_write(OFF_CONFIG, {15'h0000, i[0]});
            reg_write(OFF_ENABLE, g ? EN_IMPL_MASK & ~(16'h0001 << rows[i].gbit) : EN_IMPL_MASK);
            ack_delay <= {2'b00, i[1:0]};
            set_flags(NSRC'(1) << i);
            if (g) begin
                quiet();
                chk("blocked", {31'h0, seen}, 32'h0);
                reg_write(OFF_ENABLE, EN_IMPL_MASK);
            end
            take(rows[i].vec, i[0]);
            set_flags('0);
        end
        // traps first, then the lowest vector
        reg_write(OFF_CONFIG, 16'h0000);
        // long ack delay keeps the vector on offer while the read-only views are read
        ack_delay <= 4'hF;
        set_flags((NSRC'(1) << SRC_TRAP_FIRST) | NSRC'(1) | (NSRC'(1) << SRC_CAN2_TX));
        reg_check("flags", OFF_FLAGS, 16'h0060);
        reg_check("pending", OFF_PENDING, 16'h0001);
        reg_check("vec_reg", OFF_VECTOR, 16'h8100);
        take(7'h01, 1'b0);
        set_flags(NSRC'(1) | (NSRC'(1) << SRC_CAN2_TX));
        take(7'h36, 1'b0);
        set_flags(NSRC'(1) << SRC_CAN2_TX);
        take(7'h4F, 1'b0);
        set_flags('0);
        // masked source: no request, only the status interrupt
        reg_write(OFF_STATUS, 16'hFFFF);
        reg_write(OFF_ENABLE, 16'h0000);
        reg_write(OFF_MASK, 16'h0001);
        set_flags(26'h1 << SRC_FAULT_B);
        quiet();
        chk("masked_req", {31'h0, seen}, 32'h0);
        chk("irq_set", {31'h0, irq_out}, 32'h1);
        reg_check("status", OFF_STATUS, 16'h0001);
        reg_write(OFF_MASK, 16'h0000);
        @(negedge mclk);
        chk("irq_masked", {31'h0, irq_out}, 32'h0);
        reg_write(OFF_MASK, 16'h0001);
        set_flags('0);
        reg_write(OFF_STATUS, 16'h0001);
        @(negedge mclk);
        chk("irq_clear", {31'h0, irq_out}, 32'h0);
        reg_write(OFF_ENABLE, 16'hFFFF);
        reg_check("enable_impl", OFF_ENABLE, 16'h00F7);
        @(negedge mclk);
        chk("rdata_hold", {16'h0, reg_rdata}, 32'h0);
        reg_check("unmapped", 4'hF, 16'h0000);
        @(posedge mclk);
        rst_b <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        reg_check("enable_rerst", OFF_ENABLE, 16'h0000);
        finish_test();
    end
endmodule
`default_nettype wire
